// [rtl/csia_core.sv]
/*
 * Return-address stack, interrupt shadow registers, two indirect pointers
 * with data, linear and program memory access, and instruction screening.
 * Assumes memories answer in the cycle their strobe is high, and that
 * sw_reset_o is routed back to rst_i by the system.
 */
module csia_core (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       por_i,
  input  wire logic                       ce_i,
  // Stack
  input  wire logic                       push_i,
  input  wire logic                       pop_i,
  input  wire logic [csia_pkg::PC_W-1:0]  push_pc_i,
  output logic      [csia_pkg::PC_W-1:0]  top_pc_o,
  output logic      [csia_pkg::SP_W-1:0]  stack_depth_o,
  input  wire logic                       stack_fault_rst_en_i,
  input  wire logic [1:0]                 flag_clr_i,
  output logic      [1:0]                 power_control_status_reg_o,
  output logic                            sw_reset_o,
  // Context saving
  input  wire logic                       irq_entry_i,
  input  wire logic                       irq_return_i,
  input  wire csia_pkg::csia_ctx_t        ctx_i,
  output csia_pkg::csia_ctx_t             ctx_restore_o,
  output logic                            ctx_restore_valid_o,
  // Pointer writes
  input  wire logic                       ptr_wr_i,
  input  wire logic                       ptr_wsel_i,
  input  wire logic                       ptr_whigh_i,
  input  wire logic [7:0]                 ptr_wdata_i,
  output logic      [csia_pkg::PTR_W-1:0] indirect_pointer0_o,
  output logic      [csia_pkg::PTR_W-1:0] indirect_pointer1_o,
  // Indirect data port
  input  wire logic                       ind_rd_i,
  input  wire logic                       ind_wr_i,
  input  wire logic                       ind_sel_i,
  input  wire logic [7:0]                 ind_wdata_i,
  output logic      [7:0]                 ind_rdata_o,
  output logic                            ind_done_o,
  output logic                            ind_wr_ignored_o,
  output logic                            ind_busy_o,
  // Memories
  output logic      [csia_pkg::DADDR_W-1:0] dmem_addr_o,
  output logic                            dmem_rd_o,
  output logic                            dmem_we_o,
  output logic      [7:0]                 dmem_wdata_o,
  input  wire logic [7:0]                 dmem_rdata_i,
  output logic      [csia_pkg::PC_W-1:0]  pmem_addr_o,
  output logic                            pmem_rd_o,
  input  wire logic [13:0]                pmem_rdata_i,
  // Instruction screening
  input  wire logic                       instr_valid_i,
  input  wire logic [csia_pkg::OPC_W-1:0] instr_opc_i,
  output logic                            instr_exec_o,
  output logic                            instr_illegal_o
);

  // ****************************************************************
  // Return-address stack
  // ****************************************************************
  logic [csia_pkg::PC_W-1:0] stack_mem [csia_pkg::STACK_DEPTH];
  logic [csia_pkg::SP_W-1:0] sp_q;
  logic [1:0]                flags_q;
  logic                      sw_reset_q;
  logic                      push_ovf;
  logic                      pop_unf;
  assign push_ovf = push_i && !pop_i && (sp_q == csia_pkg::SP_FULL);
  assign pop_unf  = pop_i && !push_i && (sp_q == csia_pkg::SP_EMPTY);
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push_i && (sp_q != csia_pkg::SP_FULL)) begin
      stack_mem[sp_q[3:0]] <= push_pc_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sp_q <= csia_pkg::SP_EMPTY;
    end else if (ce_i) begin
      if (push_i && !push_ovf && !pop_i) begin
        sp_q <= sp_q + 5'h01;
      end else if (pop_i && !push_i && !pop_unf) begin
        sp_q <= sp_q - 5'h01;
      end
    end
  end
  assign top_pc_o = (sp_q == csia_pkg::SP_EMPTY) ? '0
                  : stack_mem[4'(sp_q - 5'h01)];
  assign stack_depth_o = sp_q;
  always_ff @(posedge clk_sys_i) begin
    if (por_i) begin
      flags_q <= 2'h0;
    end else if (ce_i) begin
      flags_q[csia_pkg::FLAG_OVF] <= push_ovf
        || (flags_q[csia_pkg::FLAG_OVF] && !flag_clr_i[csia_pkg::FLAG_OVF]);
      flags_q[csia_pkg::FLAG_UNF] <= pop_unf
        || (flags_q[csia_pkg::FLAG_UNF] && !flag_clr_i[csia_pkg::FLAG_UNF]);
    end
  end
  assign power_control_status_reg_o = flags_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_reset_q <= 1'b0;
    end else if (ce_i) begin
      sw_reset_q <= stack_fault_rst_en_i && (push_ovf || pop_unf);
    end
  end
  assign sw_reset_o = sw_reset_q;

  // ****************************************************************
  // Indirect pointers and interrupt shadows
  // ****************************************************************
  logic [csia_pkg::PTR_W-1:0] ptr_q    [csia_pkg::PTR_NUM];
  logic [csia_pkg::PTR_W-1:0] ptr_shd_q [csia_pkg::PTR_NUM];
  csia_pkg::csia_ctx_t        ctx_shd_q;
  logic                       restore_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_q[0]  <= csia_pkg::PTR_RESET;
      ptr_q[1]  <= csia_pkg::PTR_RESET;
      restore_q <= 1'b0;
    end else if (ce_i) begin
      restore_q <= irq_return_i;
      if (irq_return_i) begin
        ptr_q[0] <= ptr_shd_q[0];
        ptr_q[1] <= ptr_shd_q[1];
      end else if (ptr_wr_i && ptr_whigh_i) begin
        ptr_q[ptr_wsel_i][15:8] <= ptr_wdata_i;
      end else if (ptr_wr_i) begin
        ptr_q[ptr_wsel_i][7:0] <= ptr_wdata_i;
      end
    end
  end
  assign indirect_pointer0_o = ptr_q[0];
  assign indirect_pointer1_o = ptr_q[1];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_shd_q[0] <= csia_pkg::PTR_RESET;
      ptr_shd_q[1] <= csia_pkg::PTR_RESET;
      ctx_shd_q    <= csia_pkg::CTX_RESET;
    end else if (ce_i && irq_entry_i) begin
      ptr_shd_q[0] <= ptr_q[0];
      ptr_shd_q[1] <= ptr_q[1];
      ctx_shd_q    <= ctx_i;
    end
  end
  assign ctx_restore_o       = ctx_shd_q;
  assign ctx_restore_valid_o = restore_q;

  // ****************************************************************
  // Indirect access sequencer
  // ****************************************************************
  csia_pkg::csia_state_t       state_q;
  csia_pkg::csia_state_t       state_d;
  logic [csia_pkg::PTR_W-1:0]  sel_ptr;
  logic [12:0]                 lin_ofs;
  logic [4:0]                  lin_bank;
  logic [6:0]                  lin_idx;
  logic [csia_pkg::DADDR_W-1:0] daddr_d;
  logic [csia_pkg::DADDR_W-1:0] daddr_q;
  logic [csia_pkg::PC_W-1:0]   paddr_q;
  logic                        wr_q;
  logic                        pm_q;
  logic [7:0]                  wdata_q;
  logic [7:0]                  rdata_q;
  logic                        done_q;
  logic                        ign_q;
  logic                        take;
  assign sel_ptr  = ptr_q[ind_sel_i];
  assign take     = (state_q == csia_pkg::CSIA_IDLE)
                    && (ind_rd_i || ind_wr_i);
  // linear view of banked general RAM
  assign lin_ofs  = sel_ptr[12:0];
  assign lin_bank = 5'(lin_ofs / csia_pkg::LIN_BANK_BYTES);
  assign lin_idx  = 7'(lin_ofs % csia_pkg::LIN_BANK_BYTES);
  always_comb begin
    daddr_d = sel_ptr[csia_pkg::DADDR_W-1:0];
    if (sel_ptr[15:13] == csia_pkg::LIN_TAG) begin
      daddr_d = {lin_bank, 7'(csia_pkg::GPR_FIRST + lin_idx)};
    end
  end
  // high pointer bit picks program memory
  // extra fetch state for program memory
  always_comb begin
    state_d = state_q;
    case (state_q)
      csia_pkg::CSIA_IDLE: begin
        if (take) begin
          state_d = (sel_ptr[csia_pkg::PM_SEL_BIT] && !ind_wr_i)
                  ? csia_pkg::CSIA_PM1 : csia_pkg::CSIA_DM;
        end
      end
      csia_pkg::CSIA_PM1: state_d = csia_pkg::CSIA_PM2;
      csia_pkg::CSIA_PM2: state_d = csia_pkg::CSIA_IDLE;
      csia_pkg::CSIA_DM:  state_d = csia_pkg::CSIA_IDLE;
      default:            state_d = csia_pkg::CSIA_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= csia_pkg::CSIA_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      daddr_q <= '0;
      paddr_q <= '0;
      wr_q    <= 1'b0;
      pm_q    <= 1'b0;
      wdata_q <= 8'h00;
    end else if (ce_i && take) begin
      daddr_q <= daddr_d;
      paddr_q <= sel_ptr[csia_pkg::PC_W-1:0];
      wr_q    <= ind_wr_i;
      pm_q    <= sel_ptr[csia_pkg::PM_SEL_BIT];
      wdata_q <= ind_wdata_i;
    end
  end
  // low eight bits of program word
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (state_q == csia_pkg::CSIA_PM2) begin
        rdata_q <= pmem_rdata_i[7:0];
      end else if (state_q == csia_pkg::CSIA_DM && !wr_q) begin
        rdata_q <= dmem_rdata_i;
      end
    end
  end
  // writes aimed at program memory dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      ign_q  <= 1'b0;
    end else if (ce_i) begin
      done_q <= (state_q == csia_pkg::CSIA_DM)
             || (state_q == csia_pkg::CSIA_PM2);
      ign_q  <= (state_q == csia_pkg::CSIA_DM) && wr_q && pm_q;
    end
  end
  assign dmem_addr_o  = daddr_q;
  // no data strobes for program target
  assign dmem_rd_o    = (state_q == csia_pkg::CSIA_DM) && !wr_q && !pm_q;
  assign dmem_we_o    = (state_q == csia_pkg::CSIA_DM) && wr_q && !pm_q
                        && ce_i;
  assign dmem_wdata_o = wdata_q;
  assign pmem_addr_o  = paddr_q;
  assign pmem_rd_o    = (state_q == csia_pkg::CSIA_PM1)
                     || (state_q == csia_pkg::CSIA_PM2);
  assign ind_rdata_o      = rdata_q;
  assign ind_done_o       = done_q;
  assign ind_wr_ignored_o = ign_q;
  assign ind_busy_o       = (state_q != csia_pkg::CSIA_IDLE);

  // ****************************************************************
  // Instruction screening
  // ****************************************************************
  logic exec_q;
  logic illegal_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      exec_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else if (ce_i) begin
      exec_q    <= instr_valid_i && (instr_opc_i < csia_pkg::NUM_INSTR);
      illegal_q <= instr_valid_i && (instr_opc_i >= csia_pkg::NUM_INSTR);
    end
  end
  assign instr_exec_o    = exec_q;
  assign instr_illegal_o = illegal_q;
endmodule // csia_core

// [rtl/csia_pkg.sv]
/*
 * Constants and carrier types of the core stack and indirect access block.
 * Assumes a single core clock and a synchronous, active-high reset.
 */
package csia_pkg;

  // Return-address stack
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned PC_W        = 15;
  localparam int unsigned SP_W        = 5;
  localparam logic [SP_W-1:0] SP_FULL  = 5'h10;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;

  // Indirect pointers
  localparam int unsigned PTR_W     = 16;
  localparam int unsigned PTR_NUM   = 2;
  localparam int unsigned PM_SEL_BIT = 15;
  localparam int unsigned DADDR_W   = 12;
  localparam logic [2:0]  LIN_TAG   = 3'h1;
  localparam logic [12:0] LIN_BANK_BYTES = 13'h0050;
  localparam logic [6:0]  GPR_FIRST = 7'h20;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;

  // Instruction set size
  localparam int unsigned OPC_W     = 6;
  localparam logic [OPC_W-1:0] NUM_INSTR = 6'h31;

  // Sticky flag positions in the power-control status image
  localparam int unsigned FLAG_OVF = 1;
  localparam int unsigned FLAG_UNF = 0;

  typedef enum logic [1:0] {
    CSIA_IDLE = 2'b00,
    CSIA_DM   = 2'b01,
    CSIA_PM1  = 2'b10,
    CSIA_PM2  = 2'b11
  } csia_state_t;

  // Core registers saved on interrupt entry besides the pointers
  typedef struct packed {
    logic [7:0] wreg;
    logic [4:0] status;
    logic [4:0] bank;
    logic [6:0] pc_latch;
  } csia_ctx_t;

  localparam csia_ctx_t CTX_RESET = '0;

endpackage : csia_pkg

// [tb/csia_core_monitor.sv]
/*
 * Concurrent checks on the stack and indirect access core.
 * Assumes a bind to csia_core on its single core clock.
 */
module csia_core_monitor (
  input wire logic                         clk_sys_i,
  input wire logic                         rst_i,
  input wire logic                         por_i,
  input wire logic                         ce_i,
  input wire logic                         push_i,
  input wire logic                         pop_i,
  input wire logic [csia_pkg::SP_W-1:0]    stack_depth_o,
  input wire logic                         stack_fault_rst_en_i,
  input wire logic [1:0]                   flag_clr_i,
  input wire logic [1:0]                   power_control_status_reg_o,
  input wire logic                         sw_reset_o,
  input wire logic                         irq_return_i,
  input wire logic                         ctx_restore_valid_o,
  input wire logic                         ind_rd_i,
  input wire logic                         ind_wr_i,
  input wire logic                         ind_sel_i,
  input wire logic [csia_pkg::PTR_W-1:0]   indirect_pointer0_o,
  input wire logic [csia_pkg::PTR_W-1:0]   indirect_pointer1_o,
  input wire logic                         ind_done_o,
  input wire logic                         ind_wr_ignored_o,
  input wire logic                         ind_busy_o,
  input wire logic                         dmem_rd_o,
  input wire logic                         dmem_we_o,
  input wire logic                         pmem_rd_o,
  input wire logic                         instr_valid_i,
  input wire logic [csia_pkg::OPC_W-1:0]   instr_opc_i,
  input wire logic                         instr_exec_o,
  input wire logic                         instr_illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        full_push;
  logic        empty_pop;
  logic        rd_go;
  logic        wr_go;
  logic [15:0] sel_ptr;
  assign full_push = ce_i && push_i && !pop_i
                     && stack_depth_o == csia_pkg::SP_FULL;
  assign empty_pop = ce_i && pop_i && !push_i
                     && stack_depth_o == csia_pkg::SP_EMPTY;
  assign rd_go = ce_i && ind_rd_i && !ind_busy_o;
  assign wr_go = ce_i && ind_wr_i && !ind_busy_o;
  assign sel_ptr = ind_sel_i ? indirect_pointer1_o : indirect_pointer0_o;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ovf_set_a: assert property (full_push && !por_i
    |=> power_control_status_reg_o[1]) else $error("overflow flag not set");
  unf_set_a: assert property (empty_pop && !por_i
    |=> power_control_status_reg_o[0]) else $error("underflow flag not set");
  fault_reset_a: assert property ((full_push || empty_pop)
    && stack_fault_rst_en_i |=> sw_reset_o) else $error("no software reset");
  quiet_reset_a: assert property (ce_i && !((full_push || empty_pop)
    && stack_fault_rst_en_i) |=> !sw_reset_o) else $error("stray reset");
  flag_sticky_a: assert property (power_control_status_reg_o[1]
    && !flag_clr_i[1] && !por_i |=> power_control_status_reg_o[1])
    else $error("overflow flag lost");
  depth_max_a: assert property (stack_depth_o <= csia_pkg::SP_FULL)
    else $error("stack depth beyond sixteen");
  depth_freeze_a: assert property (!ce_i |=> $stable(stack_depth_o))
    else $error("depth moved while disabled");
  dm_read_a: assert property (rd_go && !sel_ptr[15] |=> dmem_rd_o
    && ind_busy_o ##1 ind_done_o && !ind_busy_o)
    else $error("data read timing wrong");
  pm_read_a: assert property (rd_go && sel_ptr[15] |=> pmem_rd_o [*2]
    ##1 ind_done_o) else $error("program read timing wrong");
  pm_write_a: assert property (wr_go && sel_ptr[15] |=> !dmem_we_o
    ##1 ind_done_o && ind_wr_ignored_o)
    else $error("program write not ignored");
  decode_check_a: assert property (ce_i && instr_valid_i
    |=> instr_exec_o == ($past(instr_opc_i) < 6'h31)
    && instr_illegal_o != instr_exec_o) else $error("decode result wrong");
  ctx_ret_a: assert property (ce_i && irq_return_i
    |=> ctx_restore_valid_o) else $error("no restore strobe");

  cover property (full_push);
  cover property (empty_pop);
  cover property (rd_go && sel_ptr[15]);
  cover property (wr_go && sel_ptr[15]);
endmodule // csia_core_monitor

bind csia_core csia_core_monitor i_mon (.*);

// [tb/tb_top.sv]
/*
 * Self-checking bench of csia_core: stack, flags, pointers, indirect port,
 * context shadows and decoder. Memories are modelled by address patterns.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_i = 1, por_i = 1, ce_i = 1, push_i = 0, pop_i = 0;
  logic stack_fault_rst_en_i = 0, irq_entry_i = 0, irq_return_i = 0;
  logic ptr_wr_i = 0, ptr_wsel_i = 0, ptr_whigh_i = 0, ind_rd_i = 0;
  logic ind_wr_i = 0, ind_sel_i = 0, instr_valid_i = 0;
  logic [14:0] push_pc_i = '0;
  logic [1:0] flag_clr_i = '0;
  logic [7:0] ptr_wdata_i = '0, ind_wdata_i = '0, dmem_wdata_o, ind_rdata_o;
  logic [5:0] instr_opc_i = '0;
  csia_pkg::csia_ctx_t ctx_i = '0, ctx_restore_o;
  logic [14:0] top_pc_o, pmem_addr_o;
  logic [4:0] stack_depth_o;
  logic [1:0] power_control_status_reg_o;
  logic [15:0] indirect_pointer0_o, indirect_pointer1_o;
  logic [11:0] dmem_addr_o, a;
  logic sw_reset_o, ctx_restore_valid_o, ind_done_o, ind_wr_ignored_o;
  logic ind_busy_o, dmem_rd_o, dmem_we_o, pmem_rd_o, instr_exec_o;
  logic instr_illegal_o;
  logic [7:0] w;
  int err_count = 0, checks = 0, cyc = 0, n, pm, s, i;
  wire logic [7:0] dmem_rdata_i = dmem_rd_o ? dmem_addr_o[7:0] ^ 8'h5A
                                            : ~dmem_addr_o[7:0];
  wire logic [13:0] pmem_rdata_i = {pmem_addr_o[13:8],
                                    pmem_addr_o[7:0] ^ 8'hC3};

  csia_core i_dut (.*);

  always #20 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Waits one falling edge first so a strobe is never re-raised at once
  task automatic pulse(ref logic sig);
    @(negedge clk_sys_i);
    sig = 1'b1;
    @(negedge clk_sys_i);
    sig = 1'b0;
  endtask

  task automatic wptr(input logic sel, input logic [15:0] v);
    ptr_wsel_i = sel;
    ptr_whigh_i = 1'b0;
    ptr_wdata_i = v[7:0];
    pulse(ptr_wr_i);
    ptr_whigh_i = 1'b1;
    ptr_wdata_i = v[15:8];
    pulse(ptr_wr_i);
  endtask

  // Indirect access; n counts cycles after the request up to done
  task ind(input logic rd, input logic sel, input logic [7:0] wd);
    ind_sel_i = sel;
    ind_wdata_i = wd;
    pm = 0;
    s = 0;
    if (rd) pulse(ind_rd_i);
    else pulse(ind_wr_i);
    for (n = 1; n < 9 && ind_done_o !== 1'b1; n++) begin
      if (dmem_rd_o || dmem_we_o) begin
        a = dmem_addr_o;
        w = dmem_wdata_o;
        s++;
      end
      if (pmem_rd_o === 1'b1) pm++;
      @(negedge clk_sys_i);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_i = 0;
    por_i = 0;
    chk(stack_depth_o, 0);
    chk(power_control_status_reg_o, 0);
    stack_fault_rst_en_i = 1;
    for (i = 0; i < 16; i++) begin
      push_pc_i = 15'h1000 + 15'(i);
      pulse(push_i);
      chk(stack_depth_o, i + 1);
      chk(top_pc_o, push_pc_i);
    end
    push_pc_i = 15'h7FFF;
    pulse(push_i);
    chk(power_control_status_reg_o, 2'b10);
    chk(sw_reset_o, 1);
    chk(top_pc_o, 15'h100F);
    @(negedge clk_sys_i);
    chk(sw_reset_o, 0);
    for (i = 0; i < 16; i++) begin
      chk(top_pc_o, 15'h100F - 15'(i));
      pulse(pop_i);
    end
    stack_fault_rst_en_i = 0;
    pulse(pop_i);
    chk(power_control_status_reg_o, 2'b11);
    chk(sw_reset_o, 0);
    chk(stack_depth_o, 0);
    chk(top_pc_o, 15'h0000);
    pulse(rst_i);
    chk(power_control_status_reg_o, 2'b11);
    flag_clr_i = 2'b01;
    @(negedge clk_sys_i);
    flag_clr_i = 2'b00;
    chk(power_control_status_reg_o, 2'b10);
    pulse(por_i);
    chk(power_control_status_reg_o, 2'b00);
    ce_i = 0;
    pulse(push_i);
    chk(stack_depth_o, 0);
    ce_i = 1;
    $display("stack test done");
    wptr(0, 16'h2055);
    wptr(1, 16'h8123);
    chk(indirect_pointer0_o, 16'h2055);
    chk(indirect_pointer1_o, 16'h8123);
    ind(1, 0, 8'h00);
    chk(n, 2);
    chk(a, 12'h0A5);
    chk(ind_rdata_o, 8'hFF);
    ind(1, 1, 8'h00);
    chk(n, 3);
    chk(pm, 2);
    chk(pmem_addr_o, 15'h0123);
    chk(ind_rdata_o, 8'hE0);
    ind(0, 1, 8'h77);
    chk(s, 0);
    chk(ind_wr_ignored_o, 1);
    wptr(0, 16'h0345);
    ind(0, 0, 8'h77);
    chk(s, 1);
    chk({a, w}, 20'h34577);
    ind(1, 0, 8'h00);
    chk(ind_rdata_o, 8'h1F);
    $display("indirect test done");
    ctx_i = 25'h1ABCDEF;
    pulse(irq_entry_i);
    ctx_i = '0;
    wptr(0, 16'h0001);
    pulse(irq_return_i);
    chk(ctx_restore_valid_o, 1);
    chk(ctx_restore_o, 25'h1ABCDEF);
    chk(indirect_pointer0_o, 16'h0345);
    $display("context test done");
    for (i = 0; i < 64; i++) begin
      instr_opc_i = 6'(i);
      pulse(instr_valid_i);
      chk({instr_exec_o, instr_illegal_o}, i < 49 ? 2'b10 : 2'b01);
    end
    $display("decoder test done");
    end_sim();
  end
endmodule // tb_top
